// ### hw/cssr_pkg.sv
// Purpose: Shared constants and types for the card summary status block
// Assumes: Attribute plane byte offsets as seen on the card bus
// Notes:   Field positions of the summary byte live here, though cssr_chk hard-codes bits 3 and 5
package cssr_pkg;

  // Offsets above 0x3FFF need fifteen address bits
  localparam int          CSSR_AW              = 15;
  localparam int          CSSR_DW              = 8;
  localparam logic [14:0] CSSR_OFS_SUMMARY     = 15'h4100;
  localparam logic [14:0] CSSR_OFS_WPROT       = 15'h4104;
  localparam logic [14:0] CSSR_OFS_PWRDN       = 15'h4108;
  localparam logic [14:0] CSSR_OFS_SOFT_RESTART_HOLD_FLAG      = 15'h410C;
  localparam logic [14:0] CSSR_OFS_SLEEP       = 15'h4110;
  localparam logic [7:0]  CSSR_RST_BYTE        = 8'h00;

  // Summary byte fields
  localparam int CSSR_B_READY   = 0;
  localparam int CSSR_B_SWLOCK  = 1;
  localparam int CSSR_B_INFO    = 2;
  localparam int CSSR_B_PWRDN   = 3;
  localparam int CSSR_B_MAIN    = 4;
  localparam int CSSR_B_SOFT_RESTART_HOLD_FLAG  = 5;
  localparam int CSSR_B_SLEEPLO = 6;
  localparam int CSSR_B_SLEEPHI = 7;

  // Write protection register fields
  localparam int CSSR_WP_INFO = 0;
  localparam int CSSR_WP_MAIN = 1;
  // Control register field
  localparam int CSSR_CTL_BIT = 0;

  // Card bus access bundle
  typedef struct packed {
    logic                attr;   // Attribute plane selected
    logic                rd;
    logic                wr;
    logic [CSSR_AW-1:0]  addr;
    logic [CSSR_DW-1:0]  wdata;
  } cssr_acc_t;

endpackage : cssr_pkg

// ### hw/cssr_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin levels
// Assumes: Inputs asynchronous to CLK
// Notes:   Stage one feeds stage two only
`default_nettype none
module cssr_sync
  import cssr_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RST_N,
  // Levels
  input  wire logic [W-1:0] PIN_IN,
  output var  logic [W-1:0] LEVEL_OUT
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  wire  [W-1:0] lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));

  // Change accepted only when stages two and three agree
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else begin
      s1_r  <= PIN_IN;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end
  assign LEVEL_OUT = lvl_r;
endmodule // cssr_sync
`default_nettype wire

// ### hw/cssr_top.sv
// Purpose: Card summary status register and the write gating it reports
// Assumes: Card bus access already decoded into one-cycle rd/wr strobes
// Notes:   Holds write protect, powerdown, soft reset and sleep controls
// Contract
// - Read-only summary byte at 0x4100
// - Bit 0 shows synchronised ready/busy pin
// - Bit 1 shows mechanical write-protect switch
// - Switch protected blocks every card write
// - Bits 2, 4 mirror lock flags
// - Bit 3 mirrors powerdown hold bit
// - Powerdown allows attribute plane only
// - Bit 5 mirrors soft restart hold
// - Low register-select picks attribute plane
// - Info lock rejects writes to info blocks
// - Main lock rejects other common writes
`default_nettype none
module cssr_top
  import cssr_pkg::*;
#(
  parameter int                 PAIRS     = 4,
  parameter logic [CSSR_AW-1:0] INFO_SIZE = 15'h1000
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // Card bus access, REG_SEL_N low picks attribute plane
  input  wire logic               REG_SEL_N,
  input  wire logic               RD,
  input  wire logic               WR,
  input  wire logic [CSSR_AW-1:0] ADDR,
  input  wire logic [CSSR_DW-1:0] WDATA,
  output var  logic [CSSR_DW-1:0] RDATA,
  // Pins from the card
  input  wire logic               DEVICE_READY_LINE,
  input  wire logic               WP_SWITCH,
  // Common memory access gating
  output var  logic               COMMON_EN,
  output var  logic               COMMON_WR_EN,
  // Control levels to the array
  output var  logic               POWERDOWN_HOLD_FLAG,
  output var  logic               SOFT_RESTART_HOLD_FLAG,
  output var  logic [PAIRS-1:0]   PAIR_SLEEP
);
  localparam int PW = (PAIRS > CSSR_DW) ? CSSR_DW : PAIRS;

  // Decoded card bus access
  cssr_acc_t          acc;
  // Synchronised pins, bit 1 switch, bit 0 ready
  logic [1:0]         pin_lvl;
  // Control registers
  logic               info_struct_lock_flag_r;
  logic               main_array_lock_flag_r;
  logic               powerdown_hold_bit_r;
  logic               soft_restart_hold_flag_r;
  logic [PAIRS-1:0]   sleep_r;
  logic [CSSR_DW-1:0] rdata_r;
  // Next values
  logic               info_struct_lock_flag_nxt;
  logic               main_array_lock_flag_nxt;
  logic               powerdown_hold_bit_nxt;
  logic               soft_restart_hold_flag_nxt;
  logic [PAIRS-1:0]   sleep_nxt;
  logic [CSSR_DW-1:0] rdata_nxt;

  function automatic logic hit(input cssr_acc_t          a,
                               input logic [CSSR_AW-1:0] ofs);
    hit = a.attr && (a.addr == ofs);
  endfunction

  assign acc = '{attr:  ~REG_SEL_N,
                 rd:    RD,
                 wr:    WR,
                 addr:  ADDR,
                 wdata: WDATA};

  // Both pins are asynchronous to CLK
  cssr_sync #(
    .W (2)
  ) u_sync (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .PIN_IN    ({WP_SWITCH, DEVICE_READY_LINE}),
    .LEVEL_OUT (pin_lvl)
  );

  wire ready_lvl  = pin_lvl[0];
  wire wp_switch  = pin_lvl[1];

  // Mechanical switch blocks all writes, attribute ones too
  wire wr_ok      = acc.wr && !wp_switch;
  wire wr_wprot   = wr_ok && hit(acc, CSSR_OFS_WPROT);
  wire wr_pwrdn   = wr_ok && hit(acc, CSSR_OFS_PWRDN);
  wire wr_soft_restart_hold_flag  = wr_ok && hit(acc, CSSR_OFS_SOFT_RESTART_HOLD_FLAG);
  wire wr_sleep   = wr_ok && hit(acc, CSSR_OFS_SLEEP);
  // Summary offset has no write path at all
  wire rd_summary = acc.rd && hit(acc, CSSR_OFS_SUMMARY);
  wire rd_wprot   = acc.rd && hit(acc, CSSR_OFS_WPROT);
  wire rd_pwrdn   = acc.rd && hit(acc, CSSR_OFS_PWRDN);
  wire rd_soft_restart_hold_flag  = acc.rd && hit(acc, CSSR_OFS_SOFT_RESTART_HOLD_FLAG);
  wire rd_sleep   = acc.rd && hit(acc, CSSR_OFS_SLEEP);

  // Sleep value padded to byte for readback
  wire [CSSR_DW-1:0] sleep_byte = CSSR_DW'(sleep_r);

  wire [CSSR_DW-1:0] summary;
  assign summary[CSSR_B_READY]   = ready_lvl;
  assign summary[CSSR_B_SWLOCK]  = wp_switch;
  assign summary[CSSR_B_INFO]    = info_struct_lock_flag_r;
  assign summary[CSSR_B_MAIN]    = main_array_lock_flag_r;
  assign summary[CSSR_B_PWRDN]   = powerdown_hold_bit_r;
  assign summary[CSSR_B_SOFT_RESTART_HOLD_FLAG]  = soft_restart_hold_flag_r;
  // Bit 6 set if any pair sleeps, bit 7 only if all pairs do; exact split is a best guess
  assign summary[CSSR_B_SLEEPLO] = |sleep_r;
  assign summary[CSSR_B_SLEEPHI] = &sleep_r;

  // Control registers read back, unused bits zero
  wire [CSSR_DW-1:0] wprot_byte = {{(CSSR_DW-2){1'b0}},
                                   main_array_lock_flag_r,
                                   info_struct_lock_flag_r};
  wire [CSSR_DW-1:0] pwrdn_byte = {{(CSSR_DW-1){1'b0}},
                                   powerdown_hold_bit_r};
  wire [CSSR_DW-1:0] srst_byte  = {{(CSSR_DW-1){1'b0}},
                                   soft_restart_hold_flag_r};

  // Unmapped reads keep the last byte, so a hole reads back stale data
  assign rdata_nxt =
      rd_summary ? summary    :
      rd_wprot   ? wprot_byte :
      rd_pwrdn   ? pwrdn_byte :
      rd_soft_restart_hold_flag  ? srst_byte  :
      rd_sleep   ? sleep_byte :
                   rdata_r;

  wire [PW-1:0] sleep_w = acc.wdata[PW-1:0];

  // Lock flags change together on one write
  assign info_struct_lock_flag_nxt = wr_wprot ? acc.wdata[CSSR_WP_INFO]
                                              : info_struct_lock_flag_r;
  assign main_array_lock_flag_nxt  = wr_wprot ? acc.wdata[CSSR_WP_MAIN]
                                              : main_array_lock_flag_r;

  assign powerdown_hold_bit_nxt     = wr_pwrdn ? acc.wdata[CSSR_CTL_BIT]
                                               : powerdown_hold_bit_r;

  assign soft_restart_hold_flag_nxt = wr_soft_restart_hold_flag ? acc.wdata[CSSR_CTL_BIT]
                                                : soft_restart_hold_flag_r;

  // Pairs beyond a byte keep their value; no field reaches them
  always_comb begin
    sleep_nxt = sleep_r;
    if (wr_sleep)
      sleep_nxt[PW-1:0] = sleep_w;
  end

  // Write protection
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      info_struct_lock_flag_r <= '0;
      main_array_lock_flag_r  <= '0;
    end else begin
      info_struct_lock_flag_r <= info_struct_lock_flag_nxt;
      main_array_lock_flag_r  <= main_array_lock_flag_nxt;
    end
  end

  // Powerdown hold
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      powerdown_hold_bit_r <= '0;
    else
      powerdown_hold_bit_r <= powerdown_hold_bit_nxt;
  end

  // Soft restart hold
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      soft_restart_hold_flag_r <= '0;
    else
      soft_restart_hold_flag_r <= soft_restart_hold_flag_nxt;
  end

  // Pair sleep controls
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      sleep_r <= '0;
    else
      sleep_r <= sleep_nxt;
  end

  // Registered read data holds until the next decoded read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      rdata_r <= CSSR_RST_BYTE;
    else
      rdata_r <= rdata_nxt;
  end

  // Common plane shut while powerdown is held
  wire common_sel = ~acc.attr && !powerdown_hold_bit_r;
  // Info region is the first block pair of the first pair
  wire in_info    = acc.addr < INFO_SIZE;
  wire cm_wr_ok   = !wp_switch
                  && !(in_info && info_struct_lock_flag_r)
                  && !(!in_info && main_array_lock_flag_r);

  assign RDATA                  = rdata_r;
  assign COMMON_EN              = common_sel;
  assign COMMON_WR_EN           = common_sel && acc.wr && cm_wr_ok;
  assign POWERDOWN_HOLD_FLAG    = powerdown_hold_bit_r;
  assign SOFT_RESTART_HOLD_FLAG = soft_restart_hold_flag_r;
  assign PAIR_SLEEP             = sleep_r;
endmodule // cssr_top
`default_nettype wire

// ### bench/cssr_chk.sv
// Purpose: Port checks for the summary status block
// Assumes: Pin levels held 8 cycles have settled
// Notes:   Bound into every cssr_top
`default_nettype none
module cssr_chk import cssr_pkg::*; #(parameter int PAIRS = 4) (
  // Clock, reset and bus
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic               REG_SEL_N,
  input wire logic               RD,
  input wire logic               WR,
  input wire logic [CSSR_AW-1:0] ADDR,
  input wire logic [CSSR_DW-1:0] RDATA,
  // Pins and controls
  input wire logic               DEVICE_READY_LINE,
  input wire logic               WP_SWITCH,
  input wire logic               COMMON_EN,
  input wire logic               COMMON_WR_EN,
  input wire logic               POWERDOWN_HOLD_FLAG,
  input wire logic               SOFT_RESTART_HOLD_FLAG,
  input wire logic [PAIRS-1:0]   PAIR_SLEEP
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire hit  = !REG_SEL_N && ADDR == CSSR_OFS_SUMMARY;
  wire rd_s = RD && hit;
  wire slp  = |PAIR_SLEEP;
  property p_ro; WR && hit |=> $stable(POWERDOWN_HOLD_FLAG) &&
    $stable(SOFT_RESTART_HOLD_FLAG) && $stable(PAIR_SLEEP); endproperty
  a_ro: assert property (p_ro) else $error("summary write acted");
  property p_rdy; $stable(DEVICE_READY_LINE)[*8] ##0 rd_s
    |=> RDATA[CSSR_B_READY] == $past(DEVICE_READY_LINE); endproperty
  a_rdy: assert property (p_rdy) else $error("ready bit wrong");
  property p_wpb; WP_SWITCH[*8] |-> !COMMON_WR_EN; endproperty
  a_wpb: assert property (p_wpb) else $error("write passed lock");
  property p_pd; rd_s |=> RDATA[3] == $past(POWERDOWN_HOLD_FLAG); endproperty
  a_pd: assert property (p_pd) else $error("powerdown bit wrong");
  property p_pdp; POWERDOWN_HOLD_FLAG |-> !COMMON_EN; endproperty
  a_pdp: assert property (p_pdp) else $error("common on in powerdown");
  property p_sr; rd_s |=> RDATA[5] == $past(SOFT_RESTART_HOLD_FLAG);
  endproperty
  a_sr: assert property (p_sr) else $error("soft reset bit wrong");
  property p_sel; COMMON_EN == (REG_SEL_N && !POWERDOWN_HOLD_FLAG);
  endproperty
  a_sel: assert property (p_sel) else $error("plane select wrong");
  property p_slp; rd_s |=> RDATA[CSSR_B_SLEEPLO] == $past(slp); endproperty
  a_slp: assert property (p_slp) else $error("sleep bit wrong");
  c_rd: cover property (rd_s);
  c_wp: cover property (WP_SWITCH && WR);
  c_slp: cover property (rd_s && slp);
endmodule // cssr_chk
bind cssr_top cssr_chk #(.PAIRS(PAIRS)) u_chk (.*);
`default_nettype wire

// ### bench/cssr_host.sv
// Purpose: Host socket model issuing single byte accesses
// Assumes: Strobes taken at the edge after launch
// Notes:   Released address and data lines show inverted garbage
`default_nettype none
module cssr_host import cssr_pkg::*; (
  // Clock
  input  wire logic               CLK,
  // Card bus
  output var  logic [25:0]        BUS,
  input  wire logic [CSSR_DW-1:0] RDATA,
  input  wire logic               GATE
);
  timeunit 1ns;
  timeprecision 1ns;
  initial BUS = 26'h200_0000;
  // Bus is {sel_n, rd, wr, addr, wdata}; write result is the gate level
  task automatic acc(input logic s, input logic w,
                     input logic [CSSR_AW-1:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    logic e;
    @(posedge CLK) #1;
    BUS = {s, !w, w, a, d};
    @(negedge CLK) e = GATE;
    @(posedge CLK) #1;
    q = w ? {7'h00, e} : RDATA;
    BUS = {3'b100, ~BUS[22:0]};
  endtask
endmodule // cssr_host
`default_nettype wire

// ### bench/tb.sv
// Purpose: Register level regression of the summary status block
// Assumes: Host model drives all bus accesses
// Notes:   Pins held 8 cycles before each summary read
`default_nettype none
module tb import cssr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        rdy;
  logic        wp;
  logic [25:0] bus;
  logic [7:0]  rdata;
  logic        wr_en;
  int          error_cnt = 0;
  int          n_tests = 0;
  always #4 clk = ~clk;
  cssr_host h (.CLK(clk), .BUS(bus), .RDATA(rdata), .GATE(wr_en));
  cssr_top uut (.CLK(clk), .RST_N(rst_n), .REG_SEL_N(bus[25]), .RD(bus[24]),
    .WR(bus[23]), .ADDR(bus[22:8]), .WDATA(bus[7:0]), .RDATA(rdata),
    .DEVICE_READY_LINE(rdy), .WP_SWITCH(wp), .COMMON_EN(),
    .COMMON_WR_EN(wr_en), .POWERDOWN_HOLD_FLAG(),
    .SOFT_RESTART_HOLD_FLAG(), .PAIR_SLEEP());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rs(input logic [7:0] exp);
    logic [7:0] q;
    h.acc(1'b0, 1'b0, CSSR_OFS_SUMMARY, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [CSSR_AW-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    h.acc(1'b0, 1'b1, a, d, q);
  endtask
  task automatic cw(input logic [CSSR_AW-1:0] a, input logic [7:0] exp);
    logic [7:0] q;
    h.acc(1'b1, 1'b1, a, 8'h5A, q);
    chk(q, exp);
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {rst_n, rdy, wp} = 3'b010;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    rs(8'h01);
    wr(CSSR_OFS_SUMMARY, 8'hFF);
    rs(8'h01);
    // Lock pairs cover info region only, main only, both
    for (int i = 0; i < 4; i++) begin
      wr(CSSR_OFS_WPROT, 8'(i));
      rs({3'h0, i[1], 1'b0, i[0], 2'b01});
      cw(15'h0010, {7'h00, !i[0]});
      cw(15'h2000, {7'h00, !i[1]});
    end
    wr(CSSR_OFS_WPROT, 8'h00);
    wp = 1'b1;
    repeat (8) @(posedge clk);
    rs(8'h03);
    cw(15'h2000, 8'h00);
    wr(CSSR_OFS_PWRDN, 8'h01);
    rs(8'h03);
    wp = 1'b0;
    repeat (8) @(posedge clk);
    wr(CSSR_OFS_PWRDN, 8'h01);
    rs(8'h09);
    cw(15'h2000, 8'h00);
    wr(CSSR_OFS_PWRDN, 8'h00);
    cw(15'h2000, 8'h01);
    wr(CSSR_OFS_SOFT_RESTART_HOLD_FLAG, 8'h01);
    rs(8'h21);
    wr(CSSR_OFS_SOFT_RESTART_HOLD_FLAG, 8'h00);
    wr(CSSR_OFS_SLEEP, 8'h01);
    rs(8'h41);
    wr(CSSR_OFS_SLEEP, 8'h0F);
    rs(8'hC1);
    rdy = 1'b0;
    repeat (8) @(posedge clk);
    rs(8'hC0);
    final_report;
  end
endmodule // tb
`default_nettype wire
